// *** src/dcudc_pkg.sv ***
// shared constants for the dual clock up/down counter
package dcudc_pkg;

  // ---------------------------------------------------------------------
  // widths and count limits
  // ---------------------------------------------------------------------
  localparam int          CNT_W    = 4;
  localparam logic [3:0]  CNT_ZERO = 4'h0;
  localparam logic [3:0]  CNT_ONE  = 4'h1;
  localparam logic [3:0]  DEC_MAX  = 4'h9;
  localparam logic [3:0]  BIN_MAX  = 4'hF;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [3:0]  RST_COUNT    = 4'h0;
  localparam logic        RST_CLK_IDLE = 1'b1;
  localparam logic        RST_TERM_N   = 1'b1;

endpackage

// *** src/dcudc_counter.sv ***
// dual clock up/down counter, decade or binary variant
`timescale 1ns/1ps

// Summary of operation
// - apart from clear and load, count changes only on a rising edge of the up or down clock.
// - pulsed clock selects direction; other clock is held high meanwhile.
// - decade variant counts 8421 BCD zero to nine, one step per pulse.
// - binary variant steps one state per pulse over all sixteen states.
// - load low with clear low copies preset inputs, clocks ignored.
// - after load releases, loaded value is kept and stepped from.
// - with load high, preset inputs do not affect the count.
// - clear high forces zero, over both clocks and the load.
// - binary bit toggles when lower bits all one (up) or zero (down).
// - carry low while up clock low and count at its maximum.
// - borrow low while down clock low and count at zero.
module dcudc_counter #(
  parameter int   WIDTH     = dcudc_pkg::CNT_W, // counter width
  parameter bit   IS_DECADE = 1'b0              // 1: decade, 0: binary
) (
  input  wire logic                        sys_clk,          // clock
  input  wire logic                        reset_n,          // async reset
  input  wire logic                        count_up_clock,   // up clock
  input  wire logic                        count_down_clock, // down clock
  input  wire logic                        preset_load_n,    // load, low
  input  wire logic                        async_clear,      // clear, high
  input  wire logic [dcudc_pkg::CNT_W-1:0] preset_value,     // preset data
  output logic      [dcudc_pkg::CNT_W-1:0] count_value,      // count
  output logic                             carry_out_n,      // carry, low
  output logic                             borrow_out_n      // borrow, low
);
  import dcudc_pkg::*;

  // ---------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------
  if (WIDTH != CNT_W) begin : g_bad_width
    $error("dcudc_counter supports only a four bit count");
  end

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] q;
    logic             up_prev;
    logic             dn_prev;
    logic             carry_n;
    logic             borrow_n;
  } dcudc_state_t;

  // clock history resets high, the idle level of both count clocks,
  // so leaving reset never looks like a rising edge
  localparam dcudc_state_t ST_RESET = '{
    q:        RST_COUNT,
    up_prev:  RST_CLK_IDLE,
    dn_prev:  RST_CLK_IDLE,
    carry_n:  RST_TERM_N,
    borrow_n: RST_TERM_N
  };

  localparam logic [CNT_W-1:0] TOP_VAL = IS_DECADE ? DEC_MAX : BIN_MAX;

  dcudc_state_t     st_ff;
  dcudc_state_t     nxt_st;
  logic             up_rise;
  logic             dn_rise;
  logic             ctl_idle;
  logic             up_step;
  logic             dn_step;
  logic [CNT_W-1:0] up_tog;
  logic [CNT_W-1:0] dn_tog;
  logic [CNT_W-1:0] bin_next;
  logic [CNT_W-1:0] dec_next;

  // ---------------------------------------------------------------------
  // edge detection and step qualification
  // ---------------------------------------------------------------------
  assign up_rise  = count_up_clock & ~st_ff.up_prev;
  assign dn_rise  = count_down_clock & ~st_ff.dn_prev;
  assign ctl_idle = ~async_clear & preset_load_n;
  // coincident edges break the one-clock-high convention; hold instead
  assign up_step  = ctl_idle & up_rise & ~dn_rise;
  assign dn_step  = ctl_idle & dn_rise & ~up_rise;

  // ---------------------------------------------------------------------
  // binary toggle steering
  // ---------------------------------------------------------------------
  for (genvar i = 0; i < CNT_W; i++) begin : g_tog
    if (i == 0) begin : g_lsb
      assign up_tog[i] = 1'b1;
      assign dn_tog[i] = 1'b1;
    end else begin : g_upper
      assign up_tog[i] = &st_ff.q[i-1:0];
      assign dn_tog[i] = ~|st_ff.q[i-1:0];
    end
  end

  // natural toggling gives the fifteen/zero wrap for free
  assign bin_next = st_ff.q ^ (up_step ? up_tog : dn_tog);

  // ---------------------------------------------------------------------
  // decade sequence
  // ---------------------------------------------------------------------
  // codes above nine go to zero going up, or walk down to nine going down
  always_comb begin
    dec_next = st_ff.q;
    if (up_step) begin
      if (st_ff.q >= DEC_MAX) begin
        dec_next = CNT_ZERO;
      end else begin
        dec_next = st_ff.q + CNT_ONE;
      end
    end else if (dn_step) begin
      if (st_ff.q == CNT_ZERO) begin
        dec_next = DEC_MAX;
      end else begin
        dec_next = st_ff.q - CNT_ONE;
      end
    end
  end

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  // clear, then load, then one step; all are sampled on sys_clk, so
  // clear and load act one cycle late instead of at once
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.up_prev = count_up_clock;
    nxt_st.dn_prev = count_down_clock;
    if (async_clear) begin
      nxt_st.q = CNT_ZERO;
    end else if (!preset_load_n) begin
      nxt_st.q = preset_value;
    end else if (up_step || dn_step) begin
      // preset inputs are not consulted on this path
      nxt_st.q = IS_DECADE ? dec_next : bin_next;
    end
    // terminal outputs follow the new count and current clock level
    nxt_st.carry_n  = ~((nxt_st.q == TOP_VAL) & ~count_up_clock);
    nxt_st.borrow_n = ~((nxt_st.q == CNT_ZERO) & ~count_down_clock);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count_value  = st_ff.q;
  assign carry_out_n  = st_ff.carry_n;
  assign borrow_out_n = st_ff.borrow_n;

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  AST_HOLD_NO_EDGE: assert property (
    (ctl_idle && !up_rise && !dn_rise) |=> $stable(count_value))
    else $error("count moved without a clock edge");

  AST_BOTH_EDGES_HOLD: assert property (
    (ctl_idle && up_rise && dn_rise) |=> $stable(count_value))
    else $error("count moved on coincident edges");

  AST_CLEAR_ZERO: assert property (
    async_clear |=> (count_value == CNT_ZERO))
    else $error("clear did not force zero");

  AST_LOAD_COPY: assert property (
    (!async_clear && !preset_load_n) |=>
      (count_value == $past(preset_value)))
    else $error("load did not copy preset inputs");

  AST_LOAD_KEEP: assert property (
    (!async_clear && !preset_load_n) ##1
      (ctl_idle && !up_rise && !dn_rise)[*2] |=>
      (count_value == $past(count_value, 2)))
    else $error("loaded value not kept after release");

  AST_PRESET_IGNORED: assert property (
    (ctl_idle && !up_rise && !dn_rise && $changed(preset_value)) |=>
      $stable(count_value))
    else $error("preset inputs changed the count");

  AST_BIN_UP: assert property (
    (!IS_DECADE && up_step) |=>
      (count_value == $past(count_value) + CNT_ONE))
    else $error("binary up step wrong");

  AST_BIN_DOWN: assert property (
    (!IS_DECADE && dn_step) |=>
      (count_value == $past(count_value) - CNT_ONE))
    else $error("binary down step wrong");

  AST_BIN_LSB: assert property (
    (!IS_DECADE && (up_step || dn_step)) |=>
      (count_value[0] != $past(count_value[0])))
    else $error("lowest bit did not toggle");

  AST_DEC_UP: assert property (
    (IS_DECADE && up_step && count_value < DEC_MAX) |=>
      (count_value == $past(count_value) + CNT_ONE))
    else $error("decade up step wrong");

  AST_DEC_WRAP: assert property (
    (IS_DECADE && dn_step && count_value == CNT_ZERO) |=>
      (count_value == DEC_MAX))
    else $error("decade down wrap wrong");

  AST_DEC_RANGE: assert property (
    (IS_DECADE && up_step && count_value >= DEC_MAX) |=>
      (count_value == CNT_ZERO))
    else $error("decade did not return to range");

  AST_DEC_DOWN: assert property (
    (IS_DECADE && dn_step && count_value != CNT_ZERO) |=>
      (count_value == $past(count_value) - CNT_ONE))
    else $error("decade down step wrong");

  AST_DEC_VALID: assert property (
    (IS_DECADE && ctl_idle && count_value <= DEC_MAX) |=>
      (count_value <= DEC_MAX))
    else $error("decade left the valid range");

  AST_BIN_UP_STEER: assert property (
    (!IS_DECADE && up_step && !count_value[0]) |=>
      (count_value[CNT_W-1:1] == $past(count_value[CNT_W-1:1])))
    else $error("upper bits moved on up step with lsb low");

  AST_BIN_DN_STEER: assert property (
    (!IS_DECADE && dn_step && count_value[0]) |=>
      (count_value[CNT_W-1:1] == $past(count_value[CNT_W-1:1])))
    else $error("upper bits moved on down step with lsb high");

  AST_BIN_WRAP_UP: assert property (
    (!IS_DECADE && up_step && count_value == BIN_MAX) |=>
      (count_value == CNT_ZERO))
    else $error("binary up wrap wrong");

  AST_BIN_WRAP_DOWN: assert property (
    (!IS_DECADE && dn_step && count_value == CNT_ZERO) |=>
      (count_value == BIN_MAX))
    else $error("binary down wrap wrong");

  AST_LOAD_OVER_CLOCKS: assert property (
    (!async_clear && !preset_load_n && (up_rise || dn_rise)) |=>
      (count_value == $past(preset_value)))
    else $error("clock edge disturbed a load");

  AST_CLEAR_OVER_LOAD: assert property (
    (async_clear && (!preset_load_n || up_rise || dn_rise)) |=>
      (count_value == CNT_ZERO))
    else $error("load or clock beat the clear");

  // ---------------------------------------------------------------------
  // terminal outputs
  // ---------------------------------------------------------------------
  AST_CARRY: assert property (
    1'b1 |=> (carry_out_n ==
      !((count_value == TOP_VAL) && !$past(count_up_clock))))
    else $error("carry output wrong");

  AST_BORROW: assert property (
    1'b1 |=> (borrow_out_n ==
      !((count_value == CNT_ZERO) && !$past(count_down_clock))))
    else $error("borrow output wrong");

  AST_CARRY_IDLE: assert property (
    count_up_clock |=> carry_out_n)
    else $error("carry low while up clock high");

  AST_BORROW_IDLE: assert property (
    count_down_clock |=> borrow_out_n)
    else $error("borrow low while down clock high");

  // ---------------------------------------------------------------------
  // coverage
  // ---------------------------------------------------------------------

  COV_UP_WRAP: cover property (
    up_step && count_value == TOP_VAL ##1 count_value == CNT_ZERO);

  COV_DOWN_WRAP: cover property (
    dn_step && count_value == CNT_ZERO ##1 count_value == TOP_VAL);

  COV_LOAD_THEN_COUNT: cover property (
    !preset_load_n ##1 preset_load_n [*1] ##[1:20] up_step);

  COV_BORROW_LOW: cover property (!borrow_out_n);

  COV_DEC_HIGH_CODE: cover property (
    IS_DECADE && dn_step && count_value > DEC_MAX);

endmodule

// *** test/dcudc_ctrl_model.sv ***
// control-side model driving the counter clocks, load and clear
`timescale 1ns/1ps
module dcudc_ctrl_model (
  input  wire logic       sys_clk, // clock
  output logic            up_clk,  // up clock
  output logic            dn_clk,  // down clock
  output logic            load_n,  // load, low
  output logic            clear,   // clear, high
  output logic [3:0]      preset   // preset data
);
  initial begin
    up_clk = 1'b1;
    dn_clk = 1'b1;
    load_n = 1'b1;
    clear  = 1'b0;
    preset = 4'hA;
  end
  // one level change at a falling edge, then a full cycle
  task automatic drive(input int sel, input logic lvl);
    @(negedge sys_clk);
    case (sel)
      0: up_clk = lvl;
      1: dn_clk = lvl;
      2: clear = lvl;
      default: load_n = lvl;
    endcase
    // data not held once load is gone
    if (load_n)
      preset = ~preset;
    @(negedge sys_clk);
  endtask
  // clear is never released together with load
  task automatic load(input logic [3:0] v);
    @(negedge sys_clk);
    preset = v;
    load_n = 1'b0;
    @(negedge sys_clk);
  endtask
endmodule

// *** test/test_dual_clock_up_down_counter.sv ***
// self-checking bench for the dual clock up/down counter
`timescale 1ns/1ps
module test_dual_clock_up_down_counter;
  import dcudc_pkg::*;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       up_clk, dn_clk, load_n, clear, cy_b, bo_b, cy_d, bo_d;
  logic [3:0] preset, cnt_b, cnt_d, cnt_h;
  logic [3:0] exp_b = 4'h0;
  logic [3:0] exp_d = 4'h0;
  logic [3:0] exp_h = 4'h0;
  int         fails = 0;
  int         n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  dcudc_ctrl_model ctl (.sys_clk(sys_clk), .up_clk(up_clk),
    .dn_clk(dn_clk), .load_n(load_n), .clear(clear), .preset(preset));
  dcudc_counter #(.IS_DECADE(1'b0)) uut (.sys_clk(sys_clk),
    .reset_n(reset_n), .count_up_clock(up_clk), .count_down_clock(dn_clk),
    .preset_load_n(load_n), .async_clear(clear), .preset_value(preset),
    .count_value(cnt_b), .carry_out_n(cy_b), .borrow_out_n(bo_b));
  dcudc_counter #(.IS_DECADE(1'b1)) uut_dec (.sys_clk(sys_clk),
    .reset_n(reset_n), .count_up_clock(up_clk), .count_down_clock(dn_clk),
    .preset_load_n(load_n), .async_clear(clear), .preset_value(preset),
    .count_value(cnt_d), .carry_out_n(cy_d), .borrow_out_n(bo_d));
  // upper stage rides on the binary stage's terminal outputs
  dcudc_counter #(.IS_DECADE(1'b0)) uut_hi (.sys_clk(sys_clk),
    .reset_n(reset_n),
    .count_up_clock(cy_b),
    .count_down_clock(bo_b),
    .preset_load_n(load_n), .async_clear(clear), .preset_value(preset),
    .count_value(cnt_h), .carry_out_n(), .borrow_out_n());
  // ----------------------------------------
  // compares
  // ----------------------------------------
  task automatic check_cnt(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_state;
    check_cnt(cnt_b, exp_b);
    check_cnt(cnt_d, exp_d);
    check_flag(cy_b, !(!up_clk && exp_b == BIN_MAX));
    check_flag(cy_d, !(!up_clk && exp_d == DEC_MAX));
    check_flag(bo_b, !(!dn_clk && exp_b == CNT_ZERO));
    check_flag(bo_d, !(!dn_clk && exp_d == CNT_ZERO));
  endtask
  // upper stage steps one cycle after the lower stage's edge
  task automatic check_hi;
    @(negedge sys_clk);
    check_cnt(cnt_h, exp_h);
  endtask
  // low phase must leave the count alone, rising edge steps it
  task automatic pulse(input int sel, input bit moves);
    ctl.drive(sel, 1'b0);
    check_state();
    check_cnt(cnt_h, exp_h);
    ctl.drive(sel, 1'b1);
    if (moves && sel == 0) begin
      if (exp_b == BIN_MAX)
        exp_h = exp_h + 4'h1;
      exp_b = exp_b + 4'h1;
      exp_d = (exp_d >= DEC_MAX) ? CNT_ZERO : exp_d + 4'h1;
    end
    if (moves && sel == 1) begin
      if (exp_b == CNT_ZERO)
        exp_h = exp_h - 4'h1;
      exp_b = exp_b - 4'h1;
      exp_d = (exp_d == CNT_ZERO) ? DEC_MAX : exp_d - 4'h1;
    end
    check_state();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_sweep(input int sel);
    for (int i = 0; i < 17; i++)
      pulse(sel, 1'b1);
    check_hi();
  endtask
  task automatic t_load(input logic [3:0] v);
    ctl.load(v);
    exp_b = v;
    exp_d = v;
    exp_h = v;
    check_state();
    pulse(0, 1'b0);
    ctl.drive(3, 1'b1);
    check_state();
    pulse(1, 1'b1);
    pulse(0, 1'b1);
    pulse(0, 1'b1);
    check_hi();
  endtask
  task automatic t_clear;
    ctl.load(4'h5);
    ctl.drive(2, 1'b1);
    exp_b = CNT_ZERO;
    exp_d = CNT_ZERO;
    exp_h = CNT_ZERO;
    check_state();
    pulse(0, 1'b0);
    pulse(1, 1'b0);
    ctl.drive(2, 1'b0);
    exp_b = 4'h5;
    exp_d = 4'h5;
    exp_h = 4'h5;
    check_state();
    ctl.drive(3, 1'b1);
    check_state();
    check_hi();
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    check_state();
    t_sweep(0);
    t_sweep(1);
    t_load(4'hF);
    t_load(4'h9);
    t_load(4'hC);
    t_clear();
    print_verdict();
  end
  // whole run is a few hundred cycles
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
endmodule
